// ==== isnv_pkg.sv ====
// Constants, state codes and timing counts for the two-wire slave front end.
// Assumes a 100 MHz system clock; the serial lines arrive from outside its domain.
//
// Behaviour
// RULE1: Master starts a new transfer only while the bus is idle.
// RULE2: Data line only changes while clock low; device drive holds steady while clock high.
// RULE3: Data transition while clock high is START or STOP, never a data bit.
// RULE4: Master makes every clock; device is slave only and never drives clock.
// RULE5: START is data falling with clock high; all activity ignored before it.
// RULE6: STOP is data rising with clock high; it ends any current operation.
// RULE7: Master ends every operation with a STOP.
// RULE8: Receiver acknowledges each byte by holding data low over ninth clock.
// RULE9: Matching address byte after START gets an acknowledge in ninth clock.
// RULE10: In a write transfer every further received byte is acknowledged.
// RULE11: Read mode sends eight bits, releases data, samples master acknowledge in ninth clock.
// RULE12: Master acknowledge continues sending; no acknowledge stops sending until STOP.
// RULE13: STOP after stored-setting write starts program cycle lasting at most 5 ms.
// RULE14: During program cycle the interface is deaf and data line stays released.
// RULE15: Master may poll with START plus address until acknowledged.
// RULE16: Address acknowledge withheld while program cycle runs, given after it ends.
// RULE17: Master waits 1 ms after supply stable before any operation; the bench waits only PWR_WAIT, 100 cycles (1 us).
// RULE18: Address byte is five-bit type, two pin bits, then direction bit.
// RULE19: Respond only when the two address bits match the address pins.
// RULE20: Access register at 02h selects wiper with 80h, stored setting with 00h.
// RULE21: Wiper writes keep seven low bits; top bit always reads zero.
// RULE22: Clock and data sampled synchronously; events come from sampled edges.
// RULE23: Busy flag set at qualifying STOP, cleared by counter within maximum time.

package isnv_pkg;

	// ==========================================================
	// Byte addresses and selector values
	localparam logic [7:0] ACCESS_ADDR = 8'h02;
	localparam logic [7:0] WIPER_ADDR = 8'h00;
	localparam logic [7:0] SEL_WIPER = 8'h80;
	localparam logic [7:0] SEL_STORED = 8'h00;

	// ==========================================================
	// Address byte fields
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 3;
	localparam int PIN_HIGH_BIT = 2;
	localparam int PIN_LOW_BIT = 1;
	localparam int DIR_BIT = 0;

	// ==========================================================
	// Reset values
	localparam logic [6:0] WIPER_RST = 7'h00;
	localparam logic [6:0] STORED_RST = 7'h00;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int PROG_TIME_MS = 5;
	localparam int PROG_CYCLES = PROG_TIME_MS * 1000 * CLK_MHZ;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	// ==========================================================
	// Protocol states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RECV = 5'h02,
		ST_SACK = 5'h04,
		ST_SEND = 5'h08,
		ST_MACK = 5'h10
	} isnv_state_e;

endpackage

// ==== isnv_sync.sv ====
// Two-stage synchroniser, one lane per bit.
// Assumes inputs are asynchronous to clk_sys; output is the second stage.
`timescale 1ns/1ps

module isnv_sync #(
	parameter int WIDTH = 4
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Lines
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);

	// ==========================================================
	// Per-bit two flip-flop chains
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : gLane
			logic meta_r;
			logic stab_r;
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					meta_r <= 1'b1;
					stab_r <= 1'b1;
				end else if (clkEn) begin
					meta_r <= async[gi];
					stab_r <= meta_r;
				end
			end
			assign synced[gi] = stab_r;
		end
	endgenerate

endmodule

// ==== isnv_slave.sv ====
// Two-wire serial slave with access selector, wiper and stored-setting bytes,
// and a busy period after a stored-setting write.
// Assumes an external master drives the clock line; data is open drain.
`timescale 1ns/1ps

module isnv_slave #(
	parameter logic [4:0] DEV_TYPE = 5'h13, // Arbitrary type identifier
	parameter int PROG_CYCLES = isnv_pkg::PROG_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Serial lines
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut_r,
	output logic sdaOe_r,
	// Address straps
	input wire logic addressPinHigh,
	input wire logic addressPinLow,
	// Device state
	output logic [6:0] wiperPos_r,
	output logic [6:0] storedSetting_r,
	output logic busy_r
);

	// ==========================================================
	// Synchronised inputs and edge events
	logic [3:0] syncd;
	logic sclS, sdaS, pinHighS, pinLowS;
	logic sclD_r, sdaD_r;

	isnv_sync #(.WIDTH(4)) uSync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.async({sclIn, sdaIn, addressPinHigh, addressPinLow}),
		.synced(syncd)
	); // see RULE22

	assign {sclS, sdaS, pinHighS, pinLowS} = syncd;

	// Previous sampled levels
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sclD_r <= 1'b1;
			sdaD_r <= 1'b1;
		end else if (clkEn) begin
			sclD_r <= sclS;
			sdaD_r <= sdaS;
		end
	end

	// Data edges with clock high are conditions, not bits
	wire startEv = clkEn & sclS & sclD_r & sdaD_r & ~sdaS; // see RULE3 see RULE5
	wire stopEv = clkEn & sclS & sclD_r & ~sdaD_r & sdaS; // see RULE3 see RULE6
	wire sclRise = clkEn & sclS & ~sclD_r;
	wire sclFall = clkEn & ~sclS & sclD_r;

	// ==========================================================
	// Protocol state
	isnv_pkg::isnv_state_e state_r;
	logic [3:0] bitCnt_r;
	logic [1:0] byteIdx_r;
	logic [7:0] rxShift_r, txShift_r, regAddr_r;
	logic dirRead_r, selStored_r, mackOk_r, nvPending_r;
	logic [6:0] staged_r;
	logic [31:0] progCnt_r;

	wire inRecv = (state_r == isnv_pkg::ST_RECV);
	wire byteDone = inRecv & sclFall & (bitCnt_r == isnv_pkg::BITS_PER_BYTE);
	wire typeHit = (rxShift_r[isnv_pkg::TYPE_MSB:isnv_pkg::TYPE_LSB] == DEV_TYPE); // see RULE18
	wire pinHit = (rxShift_r[isnv_pkg::PIN_HIGH_BIT] == pinHighS) &
		(rxShift_r[isnv_pkg::PIN_LOW_BIT] == pinLowS); // see RULE19
	wire addrHit = typeHit & pinHit;
	wire isAccess = (regAddr_r == isnv_pkg::ACCESS_ADDR);
	wire isWiper = (regAddr_r == isnv_pkg::WIPER_ADDR);
	// Readback keeps the top bit zero
	wire [7:0] txByte = {1'b0, selStored_r ? storedSetting_r : wiperPos_r}; // see RULE21
	wire lastTx = (bitCnt_r == isnv_pkg::LAST_TX_BIT);
	wire progDone = (progCnt_r == 32'h00000001);

	// ==========================================================
	// Bus state machine
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r <= isnv_pkg::ST_IDLE;
			bitCnt_r <= 4'h0;
			byteIdx_r <= 2'h0;
			rxShift_r <= 8'h00;
			txShift_r <= 8'h00;
			regAddr_r <= 8'h00;
			dirRead_r <= 1'b0;
			mackOk_r <= 1'b0;
			sdaOe_r <= 1'b0;
		end else if (stopEv) begin
			state_r <= isnv_pkg::ST_IDLE; // see RULE6
			sdaOe_r <= 1'b0;
		end else if (startEv) begin
			// Deaf while programming, so polling gets no acknowledge
			state_r <= busy_r ? isnv_pkg::ST_IDLE : isnv_pkg::ST_RECV; // see RULE14 see RULE16
			bitCnt_r <= 4'h0;
			byteIdx_r <= 2'h0;
			sdaOe_r <= 1'b0;
		end else begin
			unique case (state_r)
				isnv_pkg::ST_IDLE: begin
					sdaOe_r <= 1'b0;
				end
				isnv_pkg::ST_RECV: begin
					if (sclRise) begin
						rxShift_r <= {rxShift_r[6:0], sdaS};
						bitCnt_r <= bitCnt_r + 4'h1;
					end else if (byteDone) begin
						if (byteIdx_r != 2'h0) begin
							state_r <= isnv_pkg::ST_SACK; // see RULE10
							sdaOe_r <= 1'b1;
							if (byteIdx_r == 2'h1) begin
								regAddr_r <= rxShift_r;
							end
							if (byteIdx_r == 2'h1) begin
								byteIdx_r <= 2'h2;
							end
						end else if (addrHit) begin
							state_r <= isnv_pkg::ST_SACK; // see RULE9
							sdaOe_r <= 1'b1; // see RULE8
							dirRead_r <= rxShift_r[isnv_pkg::DIR_BIT];
							byteIdx_r <= 2'h1;
						end else begin
							state_r <= isnv_pkg::ST_IDLE;
						end
					end
				end
				isnv_pkg::ST_SACK: begin
					// Acknowledge held until the ninth clock falls; drive moves only after falls, see RULE2
					if (sclFall) begin
						bitCnt_r <= 4'h0;
						if (dirRead_r) begin
							state_r <= isnv_pkg::ST_SEND;
							txShift_r <= txByte;
							sdaOe_r <= ~txByte[7];
						end else begin
							state_r <= isnv_pkg::ST_RECV;
							sdaOe_r <= 1'b0;
						end
					end
				end
				isnv_pkg::ST_SEND: begin
					if (sclFall) begin
						if (lastTx) begin
							state_r <= isnv_pkg::ST_MACK; // see RULE11
							sdaOe_r <= 1'b0;
						end else begin
							txShift_r <= {txShift_r[6:0], 1'b0};
							bitCnt_r <= bitCnt_r + 4'h1;
							sdaOe_r <= ~txShift_r[6];
						end
					end
				end
				isnv_pkg::ST_MACK: begin
					if (sclRise) begin
						mackOk_r <= ~sdaS; // see RULE11
					end else if (sclFall) begin
						bitCnt_r <= 4'h0;
						if (mackOk_r) begin
							state_r <= isnv_pkg::ST_SEND; // see RULE12
							txShift_r <= txByte;
							sdaOe_r <= ~txByte[7];
						end else begin
							state_r <= isnv_pkg::ST_IDLE; // see RULE12
							sdaOe_r <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Register writes on data bytes
	wire dataByte = byteDone & (byteIdx_r == 2'h2);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			selStored_r <= 1'b0;
			wiperPos_r <= isnv_pkg::WIPER_RST;
			staged_r <= isnv_pkg::STORED_RST;
			nvPending_r <= 1'b0;
		end else if (startEv) begin
			nvPending_r <= 1'b0;
		end else if (dataByte & isAccess) begin
			if (rxShift_r == isnv_pkg::SEL_WIPER) begin
				selStored_r <= 1'b0; // see RULE20
			end else if (rxShift_r == isnv_pkg::SEL_STORED) begin
				selStored_r <= 1'b1; // see RULE20
			end
		end else if (dataByte & isWiper & ~selStored_r) begin
			wiperPos_r <= rxShift_r[6:0]; // see RULE21
		end else if (dataByte & isWiper & selStored_r) begin
			staged_r <= rxShift_r[6:0];
			nvPending_r <= 1'b1;
		end
	end

	// ==========================================================
	// Program cycle timer
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
			progCnt_r <= 32'h0;
			storedSetting_r <= isnv_pkg::STORED_RST;
		end else if (stopEv & nvPending_r & ~busy_r) begin
			busy_r <= 1'b1; // see RULE13 see RULE23
			progCnt_r <= 32'(PROG_CYCLES);
			storedSetting_r <= staged_r;
		end else if (clkEn & busy_r) begin
			progCnt_r <= progCnt_r - 32'h1;
			busy_r <= ~progDone; // see RULE23
		end
	end

	// Data line only ever pulled low
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sdaOut_r <= 1'b0;
		end else begin
			sdaOut_r <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence seqAddrMatch;
		byteDone && byteIdx_r == 2'h0 && addrHit;
	endsequence

	sequence seqAckDriven;
		state_r == isnv_pkg::ST_SACK && sdaOe_r;
	endsequence

	AST_START_RECV: assert property (startEv && !stopEv && !busy_r |=> state_r == isnv_pkg::ST_RECV) // see RULE5
		else $error("START not followed by receive");
	AST_STOP_IDLE: assert property (stopEv |=> state_r == isnv_pkg::ST_IDLE && !sdaOe_r) // see RULE6
		else $error("STOP did not end operation");
	AST_ADDR_ACK: assert property (seqAddrMatch and !startEv && !stopEv |=> seqAckDriven) // see RULE9
		else $error("Matching address not acknowledged");
	AST_ADDR_MISS: assert property (byteDone && byteIdx_r == 2'h0 && !pinHit && !startEv && !stopEv
		|=> !sdaOe_r && state_r == isnv_pkg::ST_IDLE) // see RULE19
		else $error("Mismatched address acknowledged");
	AST_WRITE_ACK: assert property (byteDone && byteIdx_r != 2'h0 && !startEv && !stopEv |=> seqAckDriven) // see RULE10
		else $error("Write byte not acknowledged");
	AST_SEND_RELEASE: assert property (state_r == isnv_pkg::ST_SEND && sclFall && lastTx && !startEv && !stopEv
		|=> state_r == isnv_pkg::ST_MACK && !sdaOe_r) // see RULE11
		else $error("Data line not released for master acknowledge");
	AST_NACK_STOPS: assert property (state_r == isnv_pkg::ST_MACK && sclFall && !mackOk_r && !startEv && !stopEv
		|=> state_r == isnv_pkg::ST_IDLE [*2]) // see RULE12
		else $error("Sending continued after no acknowledge");
	AST_BUSY_START: assert property (stopEv && nvPending_r && !busy_r |=> busy_r && progCnt_r == 32'(PROG_CYCLES)) // see RULE13
		else $error("Program cycle not started at STOP");
	AST_BUSY_DEAF: assert property (busy_r |-> !sdaOe_r) // see RULE14
		else $error("Data line driven during program cycle");
	AST_BUSY_BOUND: assert property (busy_r |-> progCnt_r <= 32'(PROG_CYCLES) && progCnt_r != 32'h0) // see RULE23
		else $error("Program counter out of range");
	AST_POLL_NOACK: assert property (startEv && busy_r && !stopEv |=> state_r == isnv_pkg::ST_IDLE) // see RULE16
		else $error("Address accepted while busy");
	AST_HIGH_STABLE: assert property (sclS && sclD_r && !$past(startEv) && !$past(stopEv) |-> $stable(sdaOe_r)) // see RULE2
		else $error("Device changed data line while clock high");
	AST_READ_MSB: assert property (state_r == isnv_pkg::ST_SACK && dirRead_r && sclFall && !startEv && !stopEv
		|=> txShift_r[7] == 1'b0) // see RULE21
		else $error("Readback top bit not zero");

endmodule

// ==== isnv_master.sv ====
// Behavioural two-wire bus master used as the far-side partner of the slave.
// Assumes an open-drain data wire with pull-up resolved by the bench.
`timescale 1ns/1ps

module isnv_master (
	// Clock
	input wire logic clk_sys,
	// Serial lines
	input wire logic sdaWire,
	output logic sclOut,
	output logic sdaLow
);
	// ==========================================================
	// Idle bus: both lines released high
	initial begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Start from idle or as repeated start; only master clocks
	task automatic start();
		sdaLow <= 1'b0;
		wt(4);
		sclOut <= 1'b1;
		wt(8);
		sdaLow <= 1'b1;
		wt(8);
		sclOut <= 1'b0;
		wt(4);
	endtask

	// Data changes only while clock low
	// One bit: eight cycles low, eight high, a 160 ns period
	task automatic bit_io(input logic tx, output logic rx);
		sdaLow <= ~tx;
		wt(6);
		sclOut <= 1'b1;
		wt(8);
		rx = sdaWire;
		sclOut <= 1'b0;
		wt(2);
	endtask

	// Eight bits MSB first plus the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ackIn, ackOut);
	endtask

	// Every operation ends with a stop
	task automatic stop();
		sdaLow <= 1'b1;
		wt(8);
		sclOut <= 1'b1;
		wt(8);
		sdaLow <= 1'b0;
		wt(8);
	endtask
endmodule

// ==== isnv_slave_tb_top.sv ====
// Self-checking bench for the two-wire slave with its busy period.
// Assumes isnv_master as bus partner; shortened program cycle.
`timescale 1ns/1ps

module isnv_slave_tb_top;
	localparam int PROG = 500;
	// Power-up wait before the first transfer, shortened like the program cycle
	localparam int PWR_WAIT = 100;
	localparam logic [4:0] TYPE = 5'h13; // Arbitrary type identifier
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic clkEn = 1'b1;
	logic pinHigh = 1'b1;
	logic pinLow = 1'b0;
	logic sclIn, sdaLow, sdaOut_r, sdaOe_r, busy_r, ack;
	logic [6:0] wiperPos_r, storedSetting_r;
	logic [7:0] rx, data;
	logic [31:0] seed = 32'h018A;
	wire sdaWire;
	int errCount = 0;
	int nChecks = 0;
	int wiper = 0;
	int stored = 0;
	int tries;

	// ==========================================================
	// Clock, wire resolution, instances
	always #5 clk_sys = ~clk_sys;
	assign sdaWire = (sdaOe_r ? sdaOut_r : 1'b1) & ~sdaLow;

	isnv_slave #(.DEV_TYPE(TYPE), .PROG_CYCLES(PROG)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
		.sclIn(sclIn), .sdaIn(sdaWire), .sdaOut_r(sdaOut_r), .sdaOe_r(sdaOe_r), .addressPinHigh(pinHigh),
		.addressPinLow(pinLow), .wiperPos_r(wiperPos_r), .storedSetting_r(storedSetting_r), .busy_r(busy_r));
	isnv_master i_mst (.clk_sys(clk_sys), .sdaWire(sdaWire), .sclOut(sclIn), .sdaLow(sdaLow));

	// ==========================================================
	// Helpers
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] b, input logic expAck);
		i_mst.xfer(b, 1'b1, rx, ack);
		check({7'h00, ack}, {7'h00, expAck});
	endtask

	// Write one register address and data byte in a full transfer
	task automatic put(input logic [7:0] ad, input logic [7:0] d);
		i_mst.start();
		wr({TYPE, pinHigh, pinLow, 1'b0}, 1'b0);
		wr(ad, 1'b0);
		wr(d, 1'b0);
		i_mst.stop();
	endtask

	// Read through repeated start: ack once, then refuse
	task automatic rd(input int exp);
		i_mst.start();
		wr({TYPE, pinHigh, pinLow, 1'b0}, 1'b0);
		wr(8'h00, 1'b0);
		i_mst.start();
		wr({TYPE, pinHigh, pinLow, 1'b1}, 1'b0);
		i_mst.xfer(8'hFF, 1'b0, rx, ack);
		check(rx, exp[7:0]);
		i_mst.xfer(8'hFF, 1'b1, rx, ack);
		check(rx, exp[7:0]);
		i_mst.stop();
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk_sys);
		errCount++;
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (PWR_WAIT) @(posedge clk_sys);
		// Wrong pins and wrong type are refused
		i_mst.start();
		wr({TYPE, ~pinHigh, pinLow, 1'b0}, 1'b1);
		i_mst.stop();
		i_mst.start();
		wr({TYPE ^ 5'h01, pinHigh, pinLow, 1'b0}, 1'b1);
		i_mst.stop();
		// Stored setting write starts the busy period
		data = rnd();
		put(8'h02, 8'h00);
		put(8'h00, data);
		stored = data[6:0];
		check({7'h00, busy_r}, 8'h01);
		check({1'b0, storedSetting_r}, stored[7:0]);
		// Clock enable low freezes the program counter past its span
		clkEn <= 1'b0;
		repeat (PROG + 50) @(posedge clk_sys);
		check({7'h00, busy_r}, 8'h01);
		clkEn <= 1'b1;
		// Acknowledge polling until the cycle ends
		tries = 0;
		do begin
			i_mst.start();
			i_mst.xfer({TYPE, pinHigh, pinLow, 1'b0}, 1'b1, rx, ack);
			i_mst.stop();
			tries++;
		end while (ack && tries < 8);
		check({7'h00, ack}, 8'h00);
		check({7'h00, tries > 1}, 8'h01);
		check({7'h00, busy_r}, 8'h00);
		rd(stored);
		// Wiper selection, top bit dropped, stop aborts a transfer
		put(8'h02, 8'h80);
		data = rnd() | 8'h80;
		put(8'h00, data);
		wiper = data[6:0];
		i_mst.start();
		wr({TYPE, pinHigh, pinLow, 1'b0}, 1'b0);
		wr(8'h00, 1'b0);
		i_mst.stop();
		check({1'b0, wiperPos_r}, wiper[7:0]);
		// Selector data other than the two codes leaves the choice alone
		put(8'h02, rnd() | 8'h01);
		rd(wiper);
		check({1'b0, storedSetting_r}, stored[7:0]);
		wrap_up();
	end
endmodule
